// File: rtl/synsl_pkg.sv
package synsl_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [7:0] SYNSL_ADDR_CTRL = 8'h00;
   localparam logic [7:0] SYNSL_ADDR_STATUS = 8'h04;
   localparam logic [7:0] SYNSL_ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] SYNSL_ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] SYNSL_ADDR_DIV_REF = 8'h10;
   localparam logic [7:0] SYNSL_ADDR_DIV_FB = 8'h14;

   localparam int SYNSL_IRQ_LOAD = 0;
   localparam int SYNSL_IRQ_LOST = 1;
   localparam int SYNSL_IRQ_GAIN = 2;
   localparam int SYNSL_IRQ_W = 3;
   localparam logic [2:0] SYNSL_IRQ_MASK_RST = 3'h0;

   // ==========================================================
   // Pin positions in the synchroniser vector
   // ==========================================================
   localparam int SYNSL_PIN_SEL0 = 0;
   localparam int SYNSL_PIN_SEL1 = 1;
   localparam int SYNSL_PIN_SEL2 = 2;
   localparam int SYNSL_PIN_EN = 3;
   localparam int SYNSL_PIN_CLK = 4;
   localparam int SYNSL_PIN_DATA = 5;
   localparam int SYNSL_PIN_REF = 6;
   localparam int SYNSL_PIN_FB = 7;
   localparam int SYNSL_PIN_W = 8;

   // Select code as {select_bit_2, select_bit_1, select_bit_0}.
   localparam logic [2:0] SYNSL_SEL_CODE = 3'h2;

   // ==========================================================
   // Serial frame layout
   // ==========================================================
   localparam int SYNSL_FRAME_LEN = 32;
   localparam int SYNSL_CTRL_BIT = 0;
   localparam int SYNSL_DIV_MSB = 31;
   localparam int SYNSL_DIV_LSB = 1;

   typedef struct packed {
      logic [13:0] ref_div;
      logic [9:0] main_div;
      logic [6:0] swal_div;
   } synsl_div_s;

   localparam synsl_div_s SYNSL_DIV_RST = '0;

   // ==========================================================
   // Loop filter modes
   // ==========================================================
   typedef enum logic [1:0] {
      SYNSL_MODE_NARROW = 2'b00,
      SYNSL_MODE_WIDE = 2'b01,
      SYNSL_MODE_TUNE = 2'b10
   } synsl_mode_e;

   typedef struct packed {
      logic loop_open;
      logic enable_inv;
      logic tune_sel;
   } synsl_filt_s;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int SYNSL_CLK_PERIOD_NS = 8;
   localparam int SYNSL_LOCK_WIN_NS = 80;
   localparam logic [3:0] SYNSL_LOCK_WIN_CYC =
      4'(SYNSL_LOCK_WIN_NS / SYNSL_CLK_PERIOD_NS);

endpackage

// File: rtl/synsl_top.sv
`timescale 1ns/1ns
// Operation
// - In-phase comparison drives lock indicator high.
// - Out-of-phase comparison drives lock indicator low.
// - Filter mode selects three loop control lines.
// - Gates open only for select code 010.
// - Matching address passes enable, clock, data.
// - Locked: lamp off, lock flag high.
// - Unlocked: lamp on, lock flag low.
// - Frame starts with 14-bit reference divider.
// - Then 10-bit main divider, MSB first.
// - Then 7-bit swallow divider, MSB first.
// - Latch dividers only when control bit is one.
// - Shift data on serial clock rising edge.
// - Enable high moves shift register into latches.
// - Reference divider makes the comparison frequency.
// - Main and swallow dividers divide feedback.
module synsl_top
   import synsl_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [31:0] rd_data_o,
   output logic irq_o,
   input wire logic select_bit_0_i,
   input wire logic select_bit_1_i,
   input wire logic select_bit_2_i,
   input wire logic ser_enable_i,
   input wire logic ser_clock_i,
   input wire logic ser_data_i,
   input wire logic ref_osc_i,
   input wire logic fb_prescaled_i,
   output logic modulus_ctrl_o,
   output logic lock_indicator_o,
   output logic lock_ok_flag_o,
   output logic fault_lamp_o,
   output logic loop_open_ctrl_o,
   output logic enable_inverted_ctrl_o,
   output logic tuning_select_o
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [SYNSL_PIN_W-1:0] pins_in;
   logic [SYNSL_PIN_W-1:0] sync1_r;
   logic [SYNSL_PIN_W-1:0] sync2_r;

   assign pins_in = {fb_prescaled_i, ref_osc_i, ser_data_i, ser_clock_i,
                     ser_enable_i, select_bit_2_i, select_bit_1_i,
                     select_bit_0_i};

   for (genvar gi = 0; gi < SYNSL_PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
         if (srst_i) begin
            sync1_r[gi] <= 1'b0;
            sync2_r[gi] <= 1'b0;
         end else begin
            sync1_r[gi] <= pins_in[gi];
            sync2_r[gi] <= sync1_r[gi];
         end
      end
   end

   // ==========================================================
   // Address decode and input gates
   // ==========================================================
   logic addr_ok;
   logic gclk;
   logic gen;
   logic gdata;
   logic gclk_d_r;
   logic gen_d_r;
   logic ref_d_r;
   logic fb_d_r;
   logic clk_rise;
   logic en_rise;
   logic ref_rise;
   logic fb_rise;

   // The gates are closed unless the select lines carry the code.
   assign addr_ok = {sync2_r[SYNSL_PIN_SEL2], sync2_r[SYNSL_PIN_SEL1],
                     sync2_r[SYNSL_PIN_SEL0]} == SYNSL_SEL_CODE;
   assign gclk = sync2_r[SYNSL_PIN_CLK] & addr_ok;
   assign gen = sync2_r[SYNSL_PIN_EN] & addr_ok;
   assign gdata = sync2_r[SYNSL_PIN_DATA] & addr_ok;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         gclk_d_r <= 1'b0;
         gen_d_r <= 1'b0;
         ref_d_r <= 1'b0;
         fb_d_r <= 1'b0;
      end else begin
         gclk_d_r <= gclk;
         gen_d_r <= gen;
         ref_d_r <= sync2_r[SYNSL_PIN_REF];
         fb_d_r <= sync2_r[SYNSL_PIN_FB];
      end
   end

   assign clk_rise = gclk & ~gclk_d_r;
   assign en_rise = gen & ~gen_d_r;
   assign ref_rise = sync2_r[SYNSL_PIN_REF] & ~ref_d_r;
   assign fb_rise = sync2_r[SYNSL_PIN_FB] & ~fb_d_r;

   // ==========================================================
   // Shift register and divider latches
   // ==========================================================
   logic [SYNSL_FRAME_LEN-1:0] shreg_r;
   synsl_div_s div_r;
   logic load_ev;

   // The first bit in ends at the top, so the reference field leads,
   // then main, then swallow, then the control bit at the bottom.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         shreg_r <= '0;
      end else if (clk_rise) begin
         shreg_r <= {shreg_r[SYNSL_FRAME_LEN-2:0], gdata};
      end
   end

   assign load_ev = en_rise & shreg_r[SYNSL_CTRL_BIT];

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         div_r <= SYNSL_DIV_RST;
      end else if (load_ev) begin
         div_r <= shreg_r[SYNSL_DIV_MSB:SYNSL_DIV_LSB];
      end
   end

   // ==========================================================
   // Reference and feedback dividers
   // ==========================================================
   logic [13:0] ref_cnt_r;
   logic [9:0] main_cnt_r;
   logic [6:0] swal_cnt_r;
   logic fr_pls_r;
   logic fv_pls_r;
   logic mod_r;
   logic ref_last;
   logic fb_last;

   assign ref_last = (div_r.ref_div != 14'h0000) &&
                     (ref_cnt_r >= div_r.ref_div - 14'h0001);
   assign fb_last = (div_r.main_div != 10'h000) &&
                    (main_cnt_r >= div_r.main_div - 10'h001);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ref_cnt_r <= '0;
         fr_pls_r <= 1'b0;
      end else begin
         fr_pls_r <= ref_rise & ref_last;
         if (ref_rise) begin
            ref_cnt_r <= ref_last ? 14'h0000 : ref_cnt_r + 14'h0001;
         end
      end
   end

   // The prescaler runs in its high modulus until the swallow count ends.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         main_cnt_r <= '0;
         swal_cnt_r <= '0;
         fv_pls_r <= 1'b0;
         mod_r <= 1'b0;
      end else begin
         fv_pls_r <= fb_rise & fb_last;
         mod_r <= swal_cnt_r < div_r.swal_div;
         if (fb_rise) begin
            if (fb_last) begin
               main_cnt_r <= 10'h000;
               swal_cnt_r <= 7'h00;
            end else begin
               main_cnt_r <= main_cnt_r + 10'h001;
               if (swal_cnt_r < div_r.swal_div) begin
                  swal_cnt_r <= swal_cnt_r + 7'h01;
               end
            end
         end
      end
   end

   assign modulus_ctrl_o = mod_r;

   // ==========================================================
   // Lock detector and fault circuit
   // ==========================================================
   logic pend_r;
   logic pend_fv_r;
   logic [3:0] win_cnt_r;
   logic lock_ind_r;
   logic other_pls;
   logic in_phase;
   logic timeout;

   assign other_pls = pend_fv_r ? fr_pls_r : fv_pls_r;
   assign in_phase = pend_r ? other_pls : (fr_pls_r & fv_pls_r);
   assign timeout = pend_r & ~other_pls &
                    (win_cnt_r == SYNSL_LOCK_WIN_CYC);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pend_r <= 1'b0;
         pend_fv_r <= 1'b0;
         win_cnt_r <= '0;
      end else if (pend_r) begin
         if (in_phase || timeout) begin
            pend_r <= 1'b0;
         end else begin
            win_cnt_r <= win_cnt_r + 4'h1;
         end
      end else if ((fr_pls_r ^ fv_pls_r) == 1'b1) begin
         pend_r <= 1'b1;
         pend_fv_r <= fv_pls_r;
         win_cnt_r <= 4'h0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         lock_ind_r <= 1'b0;
      end else if (in_phase) begin
         lock_ind_r <= 1'b1;
      end else if (timeout) begin
         lock_ind_r <= 1'b0;
      end
   end

   assign lock_indicator_o = lock_ind_r;
   assign lock_ok_flag_o = lock_ind_r;
   assign fault_lamp_o = ~lock_ind_r;

   // ==========================================================
   // Loop filter control
   // ==========================================================
   synsl_mode_e mode_r;
   synsl_filt_s filt_r;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         filt_r <= '0;
      end else begin
         unique case (mode_r)
            SYNSL_MODE_NARROW: filt_r <= 3'h2;
            SYNSL_MODE_WIDE: filt_r <= 3'h0;
            SYNSL_MODE_TUNE: filt_r <= 3'h5;
            default: filt_r <= 3'h2;
         endcase
      end
   end

   assign loop_open_ctrl_o = filt_r.loop_open;
   assign enable_inverted_ctrl_o = filt_r.enable_inv;
   assign tuning_select_o = filt_r.tune_sel;

   // ==========================================================
   // Register port and interrupts
   // ==========================================================
   logic [SYNSL_IRQ_W-1:0] irq_stat_r;
   logic [SYNSL_IRQ_W-1:0] irq_mask_r;
   logic [SYNSL_IRQ_W-1:0] irq_set;
   logic [SYNSL_IRQ_W-1:0] irq_clr;
   logic [31:0] rd_data_r;
   logic [31:0] rd_data_nxt;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mode_r <= SYNSL_MODE_NARROW;
         irq_mask_r <= SYNSL_IRQ_MASK_RST;
      end else if (wr_en_i) begin
         if (addr_i == SYNSL_ADDR_CTRL) begin
            mode_r <= synsl_mode_e'(wr_data_i[1:0]);
         end
         if (addr_i == SYNSL_ADDR_IRQ_MASK) begin
            irq_mask_r <= wr_data_i[SYNSL_IRQ_W-1:0];
         end
      end
   end

   assign irq_set = {~lock_ind_r & in_phase, lock_ind_r & timeout, load_ev};
   assign irq_clr = (wr_en_i && addr_i == SYNSL_ADDR_IRQ_STAT) ?
                    wr_data_i[SYNSL_IRQ_W-1:0] : 3'h0;

   // A new event wins over a clear in the same cycle.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   always_comb begin
      rd_data_nxt = 32'h0000_0000;
      if (rd_en_i) begin
         unique case (addr_i)
            SYNSL_ADDR_CTRL: rd_data_nxt = {30'h0000_0000, mode_r};
            SYNSL_ADDR_STATUS: rd_data_nxt = {31'h0000_0000, lock_ind_r};
            SYNSL_ADDR_IRQ_STAT: rd_data_nxt = {29'h0000_0000, irq_stat_r};
            SYNSL_ADDR_IRQ_MASK: rd_data_nxt = {29'h0000_0000, irq_mask_r};
            SYNSL_ADDR_DIV_REF: rd_data_nxt = {18'h0_0000, div_r.ref_div};
            SYNSL_ADDR_DIV_FB:
               rd_data_nxt = {15'h0000, div_r.main_div, div_r.swal_div};
            default: rd_data_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data_o = rd_data_r;

   // ==========================================================
   // Assertions
   // ==========================================================
   property p_gate_code;
      @(posedge ref_clk_i) disable iff (srst_i)
      (sync2_r[SYNSL_PIN_SEL1] && !sync2_r[SYNSL_PIN_SEL0] &&
       !sync2_r[SYNSL_PIN_SEL2] && sync2_r[SYNSL_PIN_CLK]) |-> gclk;
   endproperty
   a_gate_code: assert property (p_gate_code)
      else $error("Matching select code did not open the clock gate.");

   property p_blocked;
      @(posedge ref_clk_i) disable iff (srst_i)
      !addr_ok |=> $stable(shreg_r) && $stable(div_r);
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("Serial state changed while the address did not match.");

   property p_shift;
      @(posedge ref_clk_i) disable iff (srst_i)
      (addr_ok && clk_rise) |=>
      shreg_r == {$past(shreg_r[SYNSL_FRAME_LEN-2:0]),
                  $past(sync2_r[SYNSL_PIN_DATA])};
   endproperty
   a_shift: assert property (p_shift)
      else $error("Serial clock edge did not shift in the data bit.");

   property p_latch;
      @(posedge ref_clk_i) disable iff (srst_i)
      (addr_ok && en_rise && shreg_r[SYNSL_CTRL_BIT]) |=>
      div_r == $past(shreg_r[SYNSL_DIV_MSB:SYNSL_DIV_LSB]);
   endproperty
   a_latch: assert property (p_latch)
      else $error("Enable with control bit set did not latch dividers.");

   property p_no_latch;
      @(posedge ref_clk_i) disable iff (srst_i)
      (en_rise && !shreg_r[SYNSL_CTRL_BIT]) |=> $stable(div_r);
   endproperty
   a_no_latch: assert property (p_no_latch)
      else $error("Dividers latched with the control bit clear.");

   property p_lock_high;
      @(posedge ref_clk_i) disable iff (srst_i)
      in_phase |=> lock_indicator_o && lock_ok_flag_o && !fault_lamp_o;
   endproperty
   a_lock_high: assert property (p_lock_high)
      else $error("In-phase comparison did not raise the lock indicator.");

   property p_lock_low;
      @(posedge ref_clk_i) disable iff (srst_i)
      timeout |=> !lock_indicator_o && fault_lamp_o;
   endproperty
   a_lock_low: assert property (p_lock_low)
      else $error("Missed comparison did not drop the lock indicator.");

   property p_fault;
      @(posedge ref_clk_i) disable iff (srst_i)
      lock_indicator_o == lock_ok_flag_o &&
      fault_lamp_o == !lock_ok_flag_o;
   endproperty
   a_fault: assert property (p_fault)
      else $error("Lamp and lock flag disagree with the lock indicator.");

   property p_tune;
      @(posedge ref_clk_i) disable iff (srst_i)
      (mode_r == SYNSL_MODE_TUNE) |=>
      tuning_select_o && loop_open_ctrl_o && !enable_inverted_ctrl_o;
   endproperty
   a_tune: assert property (p_tune)
      else $error("Tuning mode did not drive the tuning filter lines.");

   property p_ref_div;
      @(posedge ref_clk_i) disable iff (srst_i)
      (ref_rise && ref_last) |=> fr_pls_r ##1 (ref_cnt_r == 14'h0000);
   endproperty
   a_ref_div: assert property (p_ref_div)
      else $error("Reference divider did not wrap at its terminal count.");

   property p_fb_div;
      @(posedge ref_clk_i) disable iff (srst_i)
      (fb_rise && fb_last) |=> fv_pls_r && main_cnt_r == 10'h000;
   endproperty
   a_fb_div: assert property (p_fb_div)
      else $error("Feedback divider did not wrap at its terminal count.");

   c_load: cover property (@(posedge ref_clk_i) disable iff (srst_i)
      load_ev ##1 div_r != SYNSL_DIV_RST);
   c_gain: cover property (@(posedge ref_clk_i) disable iff (srst_i)
      !lock_ind_r ##1 lock_ind_r);
   c_lost: cover property (@(posedge ref_clk_i) disable iff (srst_i)
      lock_ind_r ##1 !lock_ind_r);

endmodule

// File: tb/synsl_ctrl_model.sv
`timescale 1ns/1ns
// ==========================================================
// Shelf controller: select code and serial load lines
// ==========================================================
module synsl_ctrl_model (
   input wire logic ref_clk_i,
   output logic select_bit_0_o,
   output logic select_bit_1_o,
   output logic select_bit_2_o,
   output logic ser_enable_o,
   output logic ser_clock_o,
   output logic ser_data_o
);
   initial begin
      {select_bit_2_o, select_bit_1_o, select_bit_0_o} = 3'h0;
      ser_enable_o = 1'b0;
      ser_clock_o = 1'b0;
      ser_data_o = 1'b0;
   end

   // Sends one whole frame MSB first, then pulses enable; hp is the
   // half period of the serial clock in system clock cycles.
   task automatic load(input logic [2:0] sel, input logic [31:0] frame,
                       input int hp);
      int i;
      {select_bit_2_o, select_bit_1_o, select_bit_0_o} <= sel;
      repeat (hp) @(posedge ref_clk_i);
      for (i = 31; i >= 0; i--) begin
         ser_data_o <= frame[i];
         repeat (hp) @(posedge ref_clk_i);
         ser_clock_o <= 1'b1;
         repeat (hp) @(posedge ref_clk_i);
         ser_clock_o <= 1'b0;
      end
      // The released data line shows the inverse of the last bit.
      ser_data_o <= ~frame[0];
      repeat (hp) @(posedge ref_clk_i);
      ser_enable_o <= 1'b1;
      repeat (hp) @(posedge ref_clk_i);
      ser_enable_o <= 1'b0;
      repeat (hp) @(posedge ref_clk_i);
      {select_bit_2_o, select_bit_1_o, select_bit_0_o} <= 3'h0;
      repeat (hp) @(posedge ref_clk_i);
   endtask
endmodule

// File: tb/synsl_top_bench.sv
`timescale 1ns/1ns
module synsl_top_bench;
   import synsl_pkg::*;
   logic ref_clk_i, srst_i, wr_en_i, rd_en_i, ref_osc_i, fb_prescaled_i;
   logic [7:0] addr_i;
   logic [31:0] wr_data_i, rd_data_o, rv;
   logic irq_o, lock_indicator_o, lock_ok_flag_o, fault_lamp_o, modulus_ctrl_o;
   logic loop_open_ctrl_o, enable_inverted_ctrl_o, tuning_select_o;
   logic select_bit_0_i, select_bit_1_i, select_bit_2_i;
   logic ser_enable_i, ser_clock_i, ser_data_i, osc_on, fb_on;
   logic [3:0] osc_cnt = 4'h0;
   int errors, n_compared;
   localparam logic [31:0] FR1 = {14'h20c5, 10'h231, 7'h45, 1'h1};

   synsl_top dut (.ref_clk_i, .srst_i, .addr_i, .wr_data_i, .wr_en_i,
      .rd_en_i, .rd_data_o, .irq_o, .select_bit_0_i, .select_bit_1_i,
      .select_bit_2_i, .ser_enable_i, .ser_clock_i, .ser_data_i,
      .ref_osc_i, .fb_prescaled_i, .modulus_ctrl_o, .lock_indicator_o,
      .lock_ok_flag_o, .fault_lamp_o, .loop_open_ctrl_o,
      .enable_inverted_ctrl_o, .tuning_select_o);

   synsl_ctrl_model ctl (.ref_clk_i, .select_bit_0_o(select_bit_0_i),
      .select_bit_1_o(select_bit_1_i), .select_bit_2_o(select_bit_2_i),
      .ser_enable_o(ser_enable_i), .ser_clock_o(ser_clock_i),
      .ser_data_o(ser_data_i));

   // ==========================================================
   // Clock, oscillators and common tasks
   // ==========================================================
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   // Feedback copies the reference so that both dividers stay in phase.
   always @(posedge ref_clk_i) begin
      osc_cnt <= (osc_cnt == 4'h9) ? 4'h0 : osc_cnt + 4'h1;
      ref_osc_i <= osc_on && osc_cnt < 4'h5;
      fb_prescaled_i <= fb_on && osc_cnt < 4'h5;
   end

   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test;
      if (errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_en_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_en_i <= 1'b0;
      #1 d = rd_data_o;
      @(posedge ref_clk_i);
   endtask

   task automatic wait_lock(input logic want);
      int k;
      @(negedge ref_clk_i);
      for (k = 0; k < 600 && lock_indicator_o !== want; k++) begin
         @(negedge ref_clk_i);
      end
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset;
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("lamp", fault_lamp_o, 1);
      chk("flag", lock_ok_flag_o, 0);
      chk("lock", lock_indicator_o, 0);
      chk("modulus", modulus_ctrl_o, 0);
      chk("irq", irq_o, 0);
      chk("filter", {loop_open_ctrl_o, enable_inverted_ctrl_o,
          tuning_select_o}, 3'h2);
      @(posedge ref_clk_i);
      rd(SYNSL_ADDR_IRQ_MASK, rv);
      chk("mask", rv, 0);
      rd(SYNSL_ADDR_DIV_REF, rv);
      chk("ref div", rv, 0);
   endtask

   task automatic t_modes;
      logic [1:0] md[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      logic [2:0] ex[4] = '{3'h0, 3'h5, 3'h2, 3'h2};
      for (int i = 0; i < 4; i++) begin
         wr(SYNSL_ADDR_CTRL, {30'h0, md[i]});
         @(negedge ref_clk_i);
         chk("filter", {loop_open_ctrl_o, enable_inverted_ctrl_o,
             tuning_select_o}, ex[i]);
         @(posedge ref_clk_i);
      end
   endtask

   task automatic t_badaddr;
      for (int c = 0; c < 8; c++) begin
         if (c != 2) begin
            ctl.load(3'(c), FR1, 10);
            rd(SYNSL_ADDR_DIV_REF, rv);
            chk("ref div kept", rv, 0);
         end
      end
      rd(SYNSL_ADDR_IRQ_STAT, rv);
      chk("no load event", rv, 0);
   endtask

   task automatic t_load;
      ctl.load(3'h2, FR1, 10);
      rd(SYNSL_ADDR_DIV_REF, rv);
      chk("ref div", rv, {18'h0, 14'h20c5});
      rd(SYNSL_ADDR_DIV_FB, rv);
      chk("fb div", rv, {15'h0, 10'h231, 7'h45});
      rd(SYNSL_ADDR_IRQ_STAT, rv);
      chk("load event", rv, 1);
      @(negedge ref_clk_i);
      chk("irq masked", irq_o, 0);
      @(posedge ref_clk_i);
      wr(SYNSL_ADDR_IRQ_MASK, 32'h7);
      @(negedge ref_clk_i);
      chk("irq on", irq_o, 1);
      @(posedge ref_clk_i);
      wr(SYNSL_ADDR_IRQ_STAT, 32'h1);
      @(negedge ref_clk_i);
      chk("irq cleared", irq_o, 0);
      @(posedge ref_clk_i);
      rd(8'h1c, rv);
      chk("unmapped", rv, 0);
      ctl.load(3'h2, {14'h1555, 10'h2aa, 7'h55, 1'h0}, 10);
      rd(SYNSL_ADDR_DIV_REF, rv);
      chk("ref div no latch", rv, {18'h0, 14'h20c5});
      rd(SYNSL_ADDR_IRQ_STAT, rv);
      chk("no latch event", rv, 0);
   endtask

   task automatic t_lock;
      ctl.load(3'h2, {14'h4, 10'h4, 7'h1, 1'h1}, 10);
      @(negedge ref_clk_i);
      chk("modulus", modulus_ctrl_o, 1);
      osc_on <= 1'b1;
      fb_on <= 1'b1;
      wait_lock(1'b1);
      chk("lock", lock_indicator_o, 1);
      chk("flag", lock_ok_flag_o, 1);
      chk("lamp", fault_lamp_o, 0);
      repeat (200) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("lock held", lock_indicator_o, 1);
      @(posedge ref_clk_i);
      rd(SYNSL_ADDR_STATUS, rv);
      chk("status", rv, 1);
      fb_on <= 1'b0;
      wait_lock(1'b0);
      chk("lock", lock_indicator_o, 0);
      chk("flag", lock_ok_flag_o, 0);
      chk("lamp", fault_lamp_o, 1);
      @(posedge ref_clk_i);
      rd(SYNSL_ADDR_IRQ_STAT, rv);
      chk("events", rv, 32'h7);
   endtask

   // ==========================================================
   // Main sequence and watchdog
   // ==========================================================
   initial begin
      errors = 0;
      n_compared = 0;
      srst_i = 1'b1;
      addr_i = 8'h0;
      wr_data_i = 32'h0;
      wr_en_i = 1'b0;
      rd_en_i = 1'b0;
      osc_on = 1'b0;
      fb_on = 1'b0;
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset;
      t_modes;
      t_badaddr;
      t_load;
      t_lock;
      end_of_test;
   end

   initial begin
      #(30000 * 8);
      errors++;
      end_of_test;
   end
endmodule
